// >>> rtl/wcu_cfg.svh
// Offsets, field positions, reset values and codes of the word comparison unit
`ifndef WCU_CFG_SVH
`define WCU_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define WCU_OFS_CTRL 8'h00
`define WCU_OFS_FLAGS 8'h04
`define WCU_OFS_RESULT 8'h08
`define WCU_OFS_IRQ_STAT 8'h0c
`define WCU_OFS_IRQ_MASK 8'h10
`define WCU_OFS_COUNT 8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define WCU_CTRL_ENABLE_BIT 0
`define WCU_FLAG_GREATER_BIT 0
`define WCU_FLAG_EQUAL_BIT 1
`define WCU_FLAG_LESS_BIT 2
`define WCU_FLAG_ERROR_BIT 3
`define WCU_IRQ_DONE_BIT 0
`define WCU_IRQ_ERROR_BIT 1

// ----------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------
`define WCU_CTRL_RESET 1'h1
`define WCU_IRQ_MASK_RESET 2'h0
`define WCU_TABLE_WORDS 16
`define WCU_TABLE_LAST 17'h0000f
`define WCU_TABLE_MATCH 16'h0000

// ----------------------------------------------------------------
// Operation codes and bus answers
// ----------------------------------------------------------------
`define WCU_OP_DOUBLE_WORD 3'h0
`define WCU_OP_TABLE_PAIR 3'h1
`define WCU_OP_SIGNED_WORD 3'h2
`define WCU_OP_SIGNED_DOUBLE 3'h3
`define WCU_OP_RANGE 3'h4
`define WCU_OP_DOUBLE_RANGE 3'h5
`define WCU_RESP_OKAY 2'h0
`define WCU_RESP_SLVERR 2'h2

`endif

// >>> rtl/wcu_mag_cmp.sv
// Magnitude comparator for 32-bit values, signed or unsigned
module wcu_mag_cmp
   import wcu_pkg::*;
(
   // Operands
   input wire logic [31:0] a,
   input wire logic [31:0] b,
   input wire logic signed_mode,
   // Relation
   output logic a_lt_b,
   output logic a_eq_b
);

   // Flipping both sign bits turns a two's complement order into an unsigned one
   always_comb begin
      a_eq_b = (a == b);
      a_lt_b = ({a[31] ^ signed_mode, a[30:0]} < {b[31] ^ signed_mode, b[30:0]});
   end

endmodule : wcu_mag_cmp

// >>> rtl/wcu_pkg.sv
// Types shared by the word comparison unit
package wcu_pkg;

   // ----------------------------------------------------------------
   // Operation selector
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      WCU_DOUBLE_WORD = 3'h0,
      WCU_TABLE_PAIR = 3'h1,
      WCU_SIGNED_WORD = 3'h2,
      WCU_SIGNED_DOUBLE = 3'h3,
      WCU_RANGE = 3'h4,
      WCU_DOUBLE_RANGE = 3'h5
   } wcu_op_t;

   // ----------------------------------------------------------------
   // Complete state of the unit
   // ----------------------------------------------------------------
   typedef struct packed {
      logic aw_held;
      logic [7:0] awaddr_h;
      logic w_held;
      logic [31:0] wdata_h;
      logic [3:0] wstrb_h;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic enable;
      logic greater;
      logic equal;
      logic less;
      logic error;
      logic [15:0] result;
      logic done;
      logic [1:0] irq_stat;
      logic [1:0] irq_mask;
      logic [15:0] count;
   } wcu_state_t;

endpackage : wcu_pkg

// >>> rtl/wcu_top.sv
// Word comparison unit: six compare operations with flags and AXI4-Lite registers
// Function
// - Double-word compare drives greater, equal, less
// - High word sits above low word
// - Table compare: bit n set when differs
// - Table equal flag only when result zero
// - Error when a table overruns its area
// - Signed 16-bit compare drives flags
// - Exactly one of three flags on
// - Signed 32-bit compare from two words
// - Range compare: below, inside, above limits
// - Range error when lower exceeds upper
// - Double range compare, same flag scheme
// - Double range error when limits reversed
// - Condition off leaves flags and result
// - Error on faulty indirect operand
`include "wcu_cfg.svh"

module wcu_top
   import wcu_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Sequencer request
   input wire logic exec_cond,
   input wire logic [2:0] op_select,
   input wire logic [31:0] first_operand,
   input wire logic [31:0] second_operand,
   input wire logic [31:0] third_operand,
   input wire logic [255:0] first_table,
   input wire logic [255:0] second_table,
   // Sequencer operand checks
   input wire logic [15:0] first_table_base,
   input wire logic [15:0] first_area_last,
   input wire logic [15:0] second_table_base,
   input wire logic [15:0] second_area_last,
   input wire logic indirect_fault,
   // Results
   output logic greater_flag,
   output logic equal_flag,
   output logic less_flag,
   output logic error_flag,
   output logic [15:0] result_word,
   output logic result_valid,
   // Interrupt
   output logic irq
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   wcu_state_t st_r;
   wcu_state_t st_nxt;

   // ----------------------------------------------------------------
   // Operand shaping
   // ----------------------------------------------------------------
   logic [31:0] cmp_a [3];
   logic [31:0] cmp_b [3];
   // Relations out of the three comparators
   logic cmp_lt [3];
   logic cmp_eq [3];
   // Decoded request and table checks
   logic signed_sel;
   logic [15:0] table_diff;
   logic [16:0] first_last_word;
   logic [16:0] second_last_word;
   logic table_overrun;
   logic op_known;

   assign signed_sel = (op_select == `WCU_OP_SIGNED_WORD) || (op_select == `WCU_OP_SIGNED_DOUBLE);

   // Pick what each of the three comparators looks at
   always_comb begin
      // Defaults serve the unsigned 32-bit operations
      cmp_a[0] = first_operand;
      cmp_b[0] = second_operand;
      cmp_a[1] = first_operand;
      cmp_b[1] = third_operand;
      cmp_a[2] = second_operand;
      cmp_b[2] = third_operand;
      unique case (op_select)
         `WCU_OP_SIGNED_WORD: begin
            cmp_a[0] = {{16{first_operand[15]}}, first_operand[15:0]};
            cmp_b[0] = {{16{second_operand[15]}}, second_operand[15:0]};
         end
         `WCU_OP_RANGE: begin
            cmp_a[0] = {16'h0000, first_operand[15:0]};
            cmp_b[0] = {16'h0000, second_operand[15:0]};
            cmp_a[1] = {16'h0000, first_operand[15:0]};
            cmp_b[1] = {16'h0000, third_operand[15:0]};
            cmp_a[2] = {16'h0000, second_operand[15:0]};
            cmp_b[2] = {16'h0000, third_operand[15:0]};
         end
         // Double-word, table, signed double and double range take the defaults
         default: begin
         end
      endcase
   end

   // upper word on bits 31:16, lower on 15:0, as the sequencer delivers
   // Comparator 0 relates first to second, 1 first to third, 2 second to third
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_cmp
         wcu_mag_cmp u_cmp (
            .a(cmp_a[gi]),
            .b(cmp_b[gi]),
            .signed_mode(signed_sel),
            .a_lt_b(cmp_lt[gi]),
            .a_eq_b(cmp_eq[gi])
         );
      end
      for (gi = 0; gi < `WCU_TABLE_WORDS; gi++) begin : g_table
         assign table_diff[gi] = (first_table[gi*16 +: 16] != second_table[gi*16 +: 16]);
      end
   endgenerate

   // ----------------------------------------------------------------
   // Table and operation checks
   // ----------------------------------------------------------------
   // last table word must stay inside its area
   // Seventeen bits keep a base near the top of the map from wrapping
   assign first_last_word = {1'b0, first_table_base} + `WCU_TABLE_LAST;
   assign second_last_word = {1'b0, second_table_base} + `WCU_TABLE_LAST;
   assign table_overrun = (first_last_word > {1'b0, first_area_last}) ||
      (second_last_word > {1'b0, second_area_last});

   // Codes 6 and 7 decode to nothing and end as an error
   assign op_known = (op_select <= `WCU_OP_DOUBLE_RANGE);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic run;
      logic fault;
      logic w_go;
      logic [31:0] wmask;
      logic [1:0] ev;
      logic [1:0] clr;
      run = 1'b0;
      fault = 1'b0;
      w_go = 1'b0;
      wmask = 32'h0000_0000;
      ev = 2'h0;
      clr = 2'h0;
      // Everything holds unless a branch below moves it
      st_nxt = st_r;
      // Result pulse lasts one cycle
      st_nxt.done = 1'b0;

      // Compare execution
      // condition off, nothing moves
      run = exec_cond && st_r.enable;
      if (run) begin
         fault = indirect_fault || !op_known;
         unique case (op_select)
            `WCU_OP_TABLE_PAIR: fault = fault || table_overrun;
            `WCU_OP_RANGE, `WCU_OP_DOUBLE_RANGE: fault = fault || cmp_lt[2] == 1'b0 && cmp_eq[2] == 1'b0;
            default: begin
            end
         endcase
         st_nxt.done = 1'b1;
         // A clean compare clears the error flag
         st_nxt.error = fault;
         // Executed compares, wrapping at 16 bits
         st_nxt.count = st_r.count + 16'h0001;
         // An error leaves the three flags and the result as they were
         if (!fault) begin
            unique case (op_select)
               `WCU_OP_TABLE_PAIR: begin
                  st_nxt.result = table_diff;
                  st_nxt.equal = (table_diff == `WCU_TABLE_MATCH);
                  // one flag on, greater stands for mismatch
                  st_nxt.greater = (table_diff != `WCU_TABLE_MATCH);
                  st_nxt.less = 1'b0;
               end
               `WCU_OP_RANGE, `WCU_OP_DOUBLE_RANGE: begin
                  st_nxt.less = cmp_lt[0];
                  st_nxt.greater = !cmp_lt[1] && !cmp_eq[1];
                  st_nxt.equal = !cmp_lt[0] && (cmp_lt[1] || cmp_eq[1]);
               end
               default: begin
                  st_nxt.less = cmp_lt[0];
                  st_nxt.equal = cmp_eq[0];
                  st_nxt.greater = !cmp_lt[0] && !cmp_eq[0];
               end
            endcase
         end
      end

      // AXI write address and data are caught independently
      if (s_axi_awvalid && s_axi_awready) begin
         st_nxt.aw_held = 1'b1;
         st_nxt.awaddr_h = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_nxt.w_held = 1'b1;
         st_nxt.wdata_h = s_axi_wdata;
         st_nxt.wstrb_h = s_axi_wstrb;
      end
      // Byte-lane mask from the held strobes
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = {8{st_r.wstrb_h[i]}};
      end

      // Register write once both halves are held
      w_go = st_r.aw_held && st_r.w_held && !st_r.bvalid;
      if (w_go) begin
         st_nxt.aw_held = 1'b0;
         st_nxt.w_held = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = `WCU_RESP_OKAY;
         unique case (st_r.awaddr_h)
            `WCU_OFS_CTRL: begin
               // Enable lives in the lowest byte lane
               if (st_r.wstrb_h[0]) begin
                  st_nxt.enable = st_r.wdata_h[`WCU_CTRL_ENABLE_BIT];
               end
            end
            `WCU_OFS_IRQ_STAT: clr = st_r.wdata_h[1:0] & wmask[1:0];
            `WCU_OFS_IRQ_MASK: begin
               st_nxt.irq_mask = (st_r.wdata_h[1:0] & wmask[1:0]) | (st_r.irq_mask & ~wmask[1:0]);
            end
            `WCU_OFS_FLAGS, `WCU_OFS_RESULT, `WCU_OFS_COUNT: begin
            end
            default: st_nxt.bresp = `WCU_RESP_SLVERR;
         endcase
      end
      // Response leaves once the master takes it
      if (st_r.bvalid && s_axi_bready) begin
         st_nxt.bvalid = 1'b0;
      end

      // Sticky events; a new event beats a clear in the same cycle
      // Any executed compare raises done, a failed one error as well
      ev[`WCU_IRQ_DONE_BIT] = run;
      ev[`WCU_IRQ_ERROR_BIT] = run && fault;
      st_nxt.irq_stat = (st_r.irq_stat & ~clr) | ev;

      // AXI read
      if (s_axi_arvalid && s_axi_arready) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = `WCU_RESP_OKAY;
         // Unused bits read as zero
         st_nxt.rdata = 32'h0000_0000;
         unique case (s_axi_araddr)
            `WCU_OFS_CTRL: st_nxt.rdata[`WCU_CTRL_ENABLE_BIT] = st_r.enable;
            `WCU_OFS_FLAGS: begin
               st_nxt.rdata[`WCU_FLAG_GREATER_BIT] = st_r.greater;
               st_nxt.rdata[`WCU_FLAG_EQUAL_BIT] = st_r.equal;
               st_nxt.rdata[`WCU_FLAG_LESS_BIT] = st_r.less;
               st_nxt.rdata[`WCU_FLAG_ERROR_BIT] = st_r.error;
            end
            `WCU_OFS_RESULT: st_nxt.rdata[15:0] = st_r.result;
            `WCU_OFS_IRQ_STAT: st_nxt.rdata[1:0] = st_r.irq_stat;
            `WCU_OFS_IRQ_MASK: st_nxt.rdata[1:0] = st_r.irq_mask;
            `WCU_OFS_COUNT: st_nxt.rdata[15:0] = st_r.count;
            default: st_nxt.rresp = `WCU_RESP_SLVERR;
         endcase
      end else if (st_r.rvalid && s_axi_rready) begin
         st_nxt.rvalid = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // flags only change on the executing edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // Counter, result and sticky bits start cleared
         st_r <= '0;
         st_r.enable <= `WCU_CTRL_RESET;
         st_r.irq_mask <= `WCU_IRQ_MASK_RESET;
         // start with equal on so one flag always shows
         st_r.equal <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Bus handshakes
   // Ready drops while a word is held, so a new one cannot overwrite it
   assign s_axi_awready = !st_r.aw_held && !st_r.bvalid;
   assign s_axi_wready = !st_r.w_held && !st_r.bvalid;
   assign s_axi_bvalid = st_r.bvalid;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_arready = !st_r.rvalid;
   assign s_axi_rvalid = st_r.rvalid;
   assign s_axi_rdata = st_r.rdata;
   assign s_axi_rresp = st_r.rresp;

   // Compare results
   assign greater_flag = st_r.greater;
   assign equal_flag = st_r.equal;
   assign less_flag = st_r.less;
   assign error_flag = st_r.error;
   assign result_word = st_r.result;
   assign result_valid = st_r.done;

   // Level interrupt from unmasked sticky bits
   assign irq = |(st_r.irq_stat & st_r.irq_mask);

endmodule : wcu_top

// >>> test/wcu_monitor.sv
// Checker of the compare port of the word comparison unit
module wcu_monitor
   import wcu_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Request
   input wire logic exec_cond,
   input wire logic [2:0] op_select,
   input wire logic [31:0] first_operand,
   input wire logic [31:0] second_operand,
   input wire logic [31:0] third_operand,
   input wire logic indirect_fault,
   // Results
   input wire logic greater_flag,
   input wire logic equal_flag,
   input wire logic less_flag,
   input wire logic error_flag,
   input wire logic [15:0] result_word,
   input wire logic result_valid
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] a_r, b_r, c_r;
   logic [2:0] op_r;
   logic flt_r, ok;
   logic [2:0] f;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Request seen at the last edge
   always_ff @(posedge aclk) begin
      a_r <= first_operand;
      b_r <= second_operand;
      c_r <= third_operand;
      op_r <= op_select;
      flt_r <= indirect_fault;
   end
   // Answer without a bad operand, and the flag triple
   assign ok = result_valid && !flt_r;
   assign f = {greater_flag, equal_flag, less_flag};
   AST_ONE: assert property ($onehot(f)) else $error("flags not one-hot");
   AST_IDLE: assert property (!$past(exec_cond) |-> !result_valid &&
      $stable({f, error_flag, result_word})) else $error("state moved while idle");
   AST_DW: assert property (ok && op_r == 3'h0 |->
      {f, error_flag} == {a_r > b_r, a_r == b_r, a_r < b_r, 1'h0}) else $error("double compare");
   AST_SW: assert property (ok && op_r == 3'h2 |-> f == {$signed(a_r[15:0]) > $signed(b_r[15:0]),
      a_r[15:0] == b_r[15:0], $signed(a_r[15:0]) < $signed(b_r[15:0])}) else $error("signed word");
   AST_SD: assert property (ok && op_r == 3'h3 |->
      f == {$signed(a_r) > $signed(b_r), a_r == b_r, $signed(a_r) < $signed(b_r)}) else $error("signed double");
   AST_TBL: assert property (ok && op_r == 3'h1 && !error_flag |->
      equal_flag == (result_word == 16'h0000)) else $error("table equal");
   AST_RNG: assert property (ok && op_r == 3'h4 |->
      error_flag == (b_r[15:0] > c_r[15:0])) else $error("range error");
   AST_DERR: assert property (ok && op_r == 3'h5 |-> error_flag == (b_r > c_r)) else $error("range2 error");
   AST_DRNG: assert property (ok && op_r == 3'h5 && b_r <= c_r |->
      f == {a_r > c_r, a_r >= b_r && a_r <= c_r, a_r < b_r}) else $error("range2 flags");
   AST_FLT: assert property (result_valid && flt_r |-> error_flag) else $error("fault not flagged");
   // Main scenarios
   cover property (ok && op_r == 3'h1 && result_word != 16'h0000);
   cover property (result_valid && error_flag);
   cover property (ok && op_r == 3'h5 && equal_flag);
endmodule : wcu_monitor

bind wcu_top wcu_monitor wcu_monitor_i (.*);

// >>> test/wcu_seq_model.sv
// Instruction sequencer model driving the compare port
module wcu_seq_model
   import wcu_pkg::*;
(
   // Clock
   input wire logic aclk,
   // Request
   output logic exec_cond,
   output logic [2:0] op_select,
   output logic [31:0] first_operand,
   output logic [31:0] second_operand,
   output logic [31:0] third_operand,
   output logic [255:0] first_table,
   output logic [255:0] second_table,
   // Operand checks
   output logic [15:0] first_table_base,
   output logic [15:0] first_area_last,
   output logic [15:0] second_table_base,
   output logic [15:0] second_area_last,
   output logic indirect_fault
);
   timeunit 1ns;
   timeprecision 1ns;
   // Quiet request at time zero
   initial begin
      {exec_cond, op_select, first_operand, second_operand, third_operand} = '0;
      {first_table, second_table, first_table_base, second_table_base, indirect_fault} = '0;
      first_area_last = 16'h00ff;
      second_area_last = 16'h00ff;
   end
   // Tables and bases for the table compare
   task automatic load(input logic [255:0] t1, t2, input logic [15:0] b1, b2);
      @(posedge aclk);
      first_table <= t1;
      second_table <= t2;
      first_table_base <= b1;
      second_table_base <= b2;
   endtask : load
   // One executed compare, then released operands flip
   task automatic issue(input logic [2:0] op, input logic [31:0] a, b, c);
      @(posedge aclk);
      exec_cond <= 1'h1;
      op_select <= op;
      first_operand <= a;
      second_operand <= b;
      third_operand <= (op == 3'h2 || op == 3'h3) ? 32'h0 : c;
      @(posedge aclk);
      exec_cond <= 1'h0;
      first_operand <= ~a;
      second_operand <= ~b;
      third_operand <= ~c;
   endtask : issue
endmodule : wcu_seq_model

// >>> test/wcu_tb_top.sv
// Self-checking bench of the word comparison unit
`include "wcu_cfg.svh"
module wcu_tb_top
   import wcu_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 1'h0, aresetn = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, first_operand, second_operand, third_operand;
   logic exec_cond, indirect_fault, greater_flag, equal_flag, less_flag, error_flag, result_valid;
   logic [2:0] op_select;
   logic [255:0] first_table, second_table;
   logic [15:0] first_table_base, first_area_last, second_table_base, second_area_last, result_word;
   int n_mismatch = 0, samples_checked = 0;
   wcu_top wcu_top_i (.*);
   wcu_seq_model wcu_seq_model_i (.*);
   // Clock of 100 ns
   always #50 aclk = ~aclk;
   // -------------------------
   // Checking and bus tasks
   // -------------------------
   task automatic end_of_test;
      if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] g, e);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic tmo(input int n);
      if (n >= 40) begin
         n_mismatch++;
         end_of_test();
      end
   endtask : tmo
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      for (n = 0; n < 40 && s_axi_bvalid !== 1'h1; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end
      s_axi_bready <= 1'h0;
      tmo(n);
      chk(s_axi_bresp, r);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      for (n = 0; n < 40 && s_axi_rvalid !== 1'h1; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end
      s_axi_rready <= 1'h0;
      tmo(n);
      chk({s_axi_rresp, s_axi_rdata}, {r, d});
   endtask : rd
   // One compare; an error keeps the three flags
   task automatic run(input logic [2:0] op, input logic [31:0] a, b, c, input logic [3:0] f);
      logic [2:0] p;
      p = {less_flag, equal_flag, greater_flag};
      wcu_seq_model_i.issue(op, a, b, c);
      #1;
      chk(result_valid, 1'h1);
      chk({error_flag, less_flag, equal_flag, greater_flag}, f[3] ? {1'h1, p} : f);
   endtask : run
   // -------------------------
   // Scenarios
   // -------------------------
   task automatic sc_regs;
      rd(`WCU_OFS_CTRL, 32'h1, 2'h0);
      rd(`WCU_OFS_FLAGS, 32'h2, 2'h0);
      wr(`WCU_OFS_FLAGS, 32'h0, 2'h0);
      rd(`WCU_OFS_FLAGS, 32'h2, 2'h0);
      rd(`WCU_OFS_IRQ_MASK, 32'h0, 2'h0);
      rd(8'h40, 32'h0, 2'h2);
      wr(8'h40, 32'h1, 2'h2);
   endtask : sc_regs
   task automatic sc_double;
      run(3'h0, 32'h0001_0000, 32'h0000_ffff, 32'h0, 4'h1);
      run(3'h0, 32'h1234_5678, 32'h1234_5678, 32'h0, 4'h2);
      run(3'h0, 32'h0000_ffff, 32'h0001_0000, 32'h0, 4'h4);
      run(3'h0, 32'h8000_0000, 32'h7fff_ffff, 32'h0, 4'h1);
   endtask : sc_double
   task automatic sc_table;
      logic [255:0] t, u;
      t = {16{16'h1234}};
      u = {16'hffff, {14{16'h1234}}, 16'h0000};
      wcu_seq_model_i.load(t, u, 16'h00f0, 16'h0000);
      run(3'h1, 32'h0, 32'h0, 32'h0, 4'h1);
      chk(result_word, 16'h8001);
      wcu_seq_model_i.load(t, t, 16'h0000, 16'h00f0);
      run(3'h1, 32'h0, 32'h0, 32'h0, 4'h2);
      chk(result_word, 16'h0000);
      wcu_seq_model_i.load(t, u, 16'h00f1, 16'h0000);
      run(3'h1, 32'h0, 32'h0, 32'h0, 4'h8);
      wcu_seq_model_i.load(t, u, 16'h0000, 16'h00f1);
      run(3'h1, 32'h0, 32'h0, 32'h0, 4'h8);
      chk(result_word, 16'h0000);
   endtask : sc_table
   task automatic sc_signed;
      run(3'h2, 32'h0000_8000, 32'h0000_0001, 32'h0, 4'h4);
      run(3'h2, 32'hffff_0001, 32'h0000_ffff, 32'h0, 4'h1);
      run(3'h3, 32'h82b6_f57b, 32'h056a_99db, 32'h0, 4'h4);
      run(3'h3, 32'h7fff_ffff, 32'h8000_0000, 32'h0, 4'h1);
   endtask : sc_signed
   task automatic sc_range;
      run(3'h4, 32'h000f, 32'h0010, 32'hab1f, 4'h4);
      run(3'h4, 32'h0010, 32'h0010, 32'hab1f, 4'h2);
      run(3'h4, 32'hab1f, 32'h0010, 32'hab1f, 4'h2);
      run(3'h4, 32'hab20, 32'h0010, 32'hab1f, 4'h1);
      run(3'h4, 32'h0005, 32'h0011, 32'h0010, 4'h8);
      run(3'h5, 32'h0000_fffe, 32'h0000_ffff, 32'h0001_0000, 4'h4);
      run(3'h5, 32'h0001_0000, 32'h0000_ffff, 32'h0001_0000, 4'h2);
      run(3'h5, 32'h0001_0001, 32'h0000_ffff, 32'h0001_0000, 4'h1);
      run(3'h5, 32'h0, 32'h0001_0000, 32'h0000_ffff, 4'h8);
   endtask : sc_range
   task automatic sc_hold;
      logic [19:0] q;
      wr(`WCU_OFS_CTRL, 32'h0, 2'h0);
      q = {result_word, error_flag, less_flag, equal_flag, greater_flag};
      wcu_seq_model_i.issue(3'h0, 32'h3, 32'h5, 32'h0);
      #1 chk(result_valid, 1'h0);
      chk({result_word, error_flag, less_flag, equal_flag, greater_flag}, q);
      wr(`WCU_OFS_CTRL, 32'h1, 2'h0);
      @(posedge aclk) wcu_seq_model_i.indirect_fault <= 1'h1;
      run(3'h0, 32'h5, 32'h3, 32'h0, 4'h8);
      @(posedge aclk) wcu_seq_model_i.indirect_fault <= 1'h0;
      run(3'h6, 32'h5, 32'h3, 32'h0, 4'h8);
   endtask : sc_hold
   task automatic sc_irq;
      wr(`WCU_OFS_IRQ_STAT, 32'h3, 2'h0);
      run(3'h0, 32'h1, 32'h1, 32'h0, 4'h2);
      chk(irq, 1'h0);
      wr(`WCU_OFS_IRQ_MASK, 32'h1, 2'h0);
      #1 chk(irq, 1'h1);
      run(3'h4, 32'h5, 32'h11, 32'h10, 4'h8);
      rd(`WCU_OFS_IRQ_STAT, 32'h3, 2'h0);
      wr(`WCU_OFS_IRQ_STAT, 32'h3, 2'h0);
      #1 chk(irq, 1'h0);
   endtask : sc_irq
   task automatic sc_rst;
      run(3'h0, 32'h9, 32'h3, 32'h0, 4'h1);
      @(posedge aclk) aresetn <= 1'h0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      rd(`WCU_OFS_FLAGS, 32'h2, 2'h0);
      rd(`WCU_OFS_COUNT, 32'h0, 2'h0);
   endtask : sc_rst
   // Reset, then the scenarios in turn
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      sc_regs();
      sc_double();
      sc_table();
      sc_signed();
      sc_range();
      sc_hold();
      sc_irq();
      sc_rst();
      end_of_test();
   end
endmodule : wcu_tb_top
